// *** swd_params.svh ***
// Constants for the standby wakeup detect block
`ifndef SWD_PARAMS_SVH
`define SWD_PARAMS_SVH
`define SWD_ADDR_W        4
`define SWD_OFF_SENSE     4'h0
`define SWD_OFF_CLEAR     4'h4
`define SWD_OFF_STATUS    4'h8
`define SWD_OFF_MASK      4'hc
`define SWD_LANE_W        8
`define SWD_EN_BIT        0
`define SWD_REC_LSB       2
`define SWD_SEL_LSB       4
`define SWD_SENSE_RST     3'h2
`define SWD_REC_RISE      2'h1
`define SWD_REC_FALL      2'h2
`endif

// *** swd_pin_drive.sv ***
// Pin source model for the external wake inputs
`timescale 1ns/1ps
module swd_pin_drive (
  input  wire logic       clk_i,
  input  wire logic [3:0] level_i,
  output logic      [3:0] pin_o
);
  initial pin_o = 4'h0;
  // Pins move away from the sampling edge, like an outside source
  always @(negedge clk_i) pin_o <= level_i;
endmodule

// *** swd_pkg.sv ***
// Types for the standby wakeup detect block
package swd_pkg;
  typedef enum logic [2:0] {
    SWD_LOW  = 3'h0,
    SWD_HIGH = 3'h1,
    SWD_FALL = 3'h2,
    SWD_RISE = 3'h3,
    SWD_BOTH = 3'h4
  } swd_sense_t;
endpackage

// *** swd_wakeup.sv ***
// Standby wakeup detector for four external pins with Wishbone registers
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "swd_params.svh"
module swd_wakeup #(
  parameter int CHANNELS = 4
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [`SWD_ADDR_W-1:0] adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  input  wire logic [CHANNELS-1:0]   ext_wake_pin_i,
  output logic      [CHANNELS-1:0]   wake_request_o,
  output logic                       irq_o
);

  initial begin
    if (CHANNELS != 4) begin
      $error("swd_wakeup serves exactly four channels");
    end
  end

  logic [CHANNELS-1:0] pin_meta;
  logic [CHANNELS-1:0] pin_sync;
  logic [CHANNELS-1:0] pin_prev;
  logic [2:0]          wake_sense_select  [CHANNELS];
  logic [1:0]          wake_edge_record   [CHANNELS];
  logic [CHANNELS-1:0] wake_source_enable;
  logic [CHANNELS-1:0] next_match;
  logic [CHANNELS-1:0] rise;
  logic [CHANNELS-1:0] fall;
  logic [CHANNELS-1:0] pend_status;
  logic [CHANNELS-1:0] pend_mask;
  logic                req;
  logic                wr;
  logic [CHANNELS-1:0] clr_hit;
  logic [31:0]         next_rdata;

  assign req = cyc_i & stb_i & ~ack_o;
  assign wr  = req & we_i;

  // Pin synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= ext_wake_pin_i;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign rise = pin_sync & ~pin_prev;
  assign fall = ~pin_sync & pin_prev;

  // Write-one-to-clear of pending bits, lane 0 of the clear register
  always_comb begin
    clr_hit = '0;
    if (wr && adr_i == `SWD_OFF_CLEAR && sel_i[0]) begin
      clr_hit = dat_i[CHANNELS-1:0];
    end
  end

  // Detection per channel
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      case (swd_pkg::swd_sense_t'(wake_sense_select[c]))
        swd_pkg::SWD_LOW:  next_match[c] = ~pin_sync[c];
        swd_pkg::SWD_HIGH: next_match[c] = pin_sync[c];
        swd_pkg::SWD_FALL: next_match[c] = fall[c];
        swd_pkg::SWD_RISE: next_match[c] = rise[c];
        swd_pkg::SWD_BOTH: next_match[c] = rise[c] | fall[c];
        default:           next_match[c] = 1'b0;
      endcase
      next_match[c] = next_match[c] & wake_source_enable[c];
    end
  end

  // Sense and enable fields, one byte lane per channel
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < CHANNELS; c++) begin
        wake_sense_select[c] <= `SWD_SENSE_RST;
      end
      wake_source_enable <= '0;
    end else if (wr && adr_i == `SWD_OFF_SENSE) begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (sel_i[c]) begin
          wake_sense_select[c] <=
            dat_i[c*`SWD_LANE_W+`SWD_SEL_LSB +: 3];
          wake_source_enable[c] <=
            dat_i[c*`SWD_LANE_W+`SWD_EN_BIT];
        end
      end
    end
  end

  // Edge record, set only in enabled both-edge mode; write-one-to-clear clears it in any mode, except in a cycle where an edge sets it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < CHANNELS; c++) begin
        wake_edge_record[c] <= '0;
      end
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (wake_source_enable[c] &&
            wake_sense_select[c] == 3'(swd_pkg::SWD_BOTH)) begin
          if (rise[c]) begin
            wake_edge_record[c] <= wake_edge_record[c] | `SWD_REC_RISE;
          end else if (fall[c]) begin
            wake_edge_record[c] <= wake_edge_record[c] | `SWD_REC_FALL;
          end else if (clr_hit[c]) begin
            wake_edge_record[c] <= '0;
          end
        end else if (clr_hit[c]) begin
          wake_edge_record[c] <= '0;
        end
      end
    end
  end

  // Standby-release request output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_request_o <= '0;
    end else begin
      wake_request_o <= next_match;
    end
  end

  // Pending status (set wins over clear) and mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_status <= '0;
    end else begin
      pend_status <= (pend_status & ~clr_hit) | next_match;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_mask <= '0;
    end else if (wr && adr_i == `SWD_OFF_MASK && sel_i[0]) begin
      pend_mask <= dat_i[CHANNELS-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((pend_status & ~clr_hit) | next_match) & pend_mask);
    end
  end

  // Read mux
  always_comb begin
    next_rdata = '0;
    case (adr_i)
      `SWD_OFF_SENSE: begin
        for (int c = 0; c < CHANNELS; c++) begin
          next_rdata[c*`SWD_LANE_W+`SWD_SEL_LSB +: 3] =
            wake_sense_select[c];
          next_rdata[c*`SWD_LANE_W+`SWD_REC_LSB +: 2] =
            wake_edge_record[c];
          next_rdata[c*`SWD_LANE_W+`SWD_EN_BIT] =
            wake_source_enable[c];
        end
      end
      `SWD_OFF_STATUS: next_rdata[CHANNELS-1:0] = pend_status;
      `SWD_OFF_MASK:   next_rdata[CHANNELS-1:0] = pend_mask;
      default:         next_rdata = '0;
    endcase
  end

  // Wishbone classic slave, one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= req;
      dat_o <= req ? next_rdata : '0;
    end
  end

endmodule

// *** swd_wakeup_bench.sv ***
// Testbench for the standby wakeup detect block
`timescale 1ns/1ps
module swd_wakeup_bench;
  logic        clk_i = 1'h0, rst_i = 1'h1, cs = 1'h0, we = 1'h0;
  logic [3:0]  adr = 4'h0, sel = 4'h0, lvl = 4'h0, pin, req;
  logic [31:0] dat = 32'h0, dat_o, q;
  logic        ack_o, irq_o;
  int          error_cnt = 0, comparisons = 0;
  initial forever #50 clk_i = ~clk_i;
  swd_pin_drive pd (.clk_i(clk_i), .level_i(lvl), .pin_o(pin));
  swd_wakeup uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cs), .stb_i(cs),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o),
    .ack_o(ack_o), .ext_wake_pin_i(pin), .wake_request_o(req),
    .irq_o(irq_o));
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, s, input logic [31:0] d);
    @(posedge clk_i);
    cs <= 1'h1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do @(posedge clk_i); while (ack_o !== 1'h1);
    q = dat_o;
    cs <= 1'h0;
  endtask
  task wr(input logic [3:0] a, s, input logic [31:0] d);
    bus(1'h1, a, s, d);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'h0, a, 4'hf, 32'h0);
    check(q, exp);
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(4'h0, 32'h20202020);
    rd(4'h3, 32'h0);
    wr(4'h0, 4'h1, 32'h40);
    wr(4'h0, 4'h1, 32'h41);
    lvl[0] <= 1'h1;
    repeat (5) @(posedge clk_i);
    rd(4'h0, 32'h20202045);
    wr(4'hc, 4'h1, 32'h1);
    repeat (2) @(posedge clk_i);
    check(32'(irq_o), 32'h1);
    lvl[0] <= 1'h0;
    repeat (5) @(posedge clk_i);
    rd(4'h0, 32'h2020204d);
    wr(4'h4, 4'h1, 32'h1);
    rd(4'h0, 32'h20202041);
    rd(4'h8, 32'h0);
    check(32'(irq_o), 32'h0);
    $display("edge record test done");
    // Only legal codes are written here
    for (int k = 0; k < 4; k++) begin
      lvl[1] <= ~k[0];
      repeat (5) @(posedge clk_i);
      wr(4'h0, 4'h2, 32'(k) << 12);
      wr(4'h0, 4'h2, (32'(k) << 12) | 32'h100);
      wr(4'h4, 4'h1, 32'h2);
      lvl[1] <= k[0];
      repeat (5) @(posedge clk_i);
      if (k < 2) check(32'(req), 32'h2);
      rd(4'h8, 32'h2);
      wr(4'h0, 4'h2, 32'h0);
      wr(4'h4, 4'h1, 32'h2);
    end
    $display("sense code test done");
    complete_run();
  end
endmodule

// *** swd_wakeup_checker.sv ***
// Port assertions for the standby wakeup detect block
`timescale 1ns/1ps
`include "swd_params.svh"
module swd_wakeup_checker #(
  parameter int CHANNELS = 4
) (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   cyc_i,
  input wire logic                   stb_i,
  input wire logic                   we_i,
  input wire logic [`SWD_ADDR_W-1:0] adr_i,
  input wire logic [3:0]             sel_i,
  input wire logic [31:0]            dat_i,
  input wire logic [31:0]            dat_o,
  input wire logic                   ack_o,
  input wire logic [CHANNELS-1:0]    ext_wake_pin_i,
  input wire logic [CHANNELS-1:0]    wake_request_o,
  input wire logic                   irq_o
);
  logic [31:0] sh;
  logic [3:0]  mk;
  wire  [3:0]  en = {sh[24], sh[16], sh[8], sh[0]};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take; cyc_i && stb_i && !ack_o; endsequence
  sequence s_rd0; s_take ##0 (!we_i && adr_i == `SWD_OFF_SENSE); endsequence
  // Shadow of the written control fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh <= 32'h20202020;
      mk <= 4'h0;
    end else if (cyc_i && stb_i && !ack_o && we_i) begin
      for (int b = 0; b < 4; b++)
        if (sel_i[b] && adr_i == `SWD_OFF_SENSE) sh[8*b+:8] <= dat_i[8*b+:8];
      if (sel_i[0] && adr_i == `SWD_OFF_MASK) mk <= dat_i[3:0];
    end
  end
  a_ack_answers: assert property (s_take |=> ack_o)
    else $error("no ack after request");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  a_sense_readback: assert property (
    s_rd0 |=> (dat_o & 32'h71717171) == (sh & 32'h71717171))
    else $error("sense or enable readback wrong");
  a_spare_bits_zero: assert property (
    s_rd0 |=> (dat_o & 32'h82828282) == 32'h0)
    else $error("spare bits not zero");
  a_unmapped_zero: assert property (
    s_take ##0 (!we_i && adr_i[1:0] != 2'h0) |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_req_enabled: assert property (
    (wake_request_o & ~(en | $past(en))) == 4'h0)
    else $error("request from disabled channel");
  a_irq_masked: assert property (irq_o |-> (mk | $past(mk)) != 4'h0)
    else $error("irq with all masked");
endmodule
bind swd_wakeup swd_wakeup_checker #(.CHANNELS(CHANNELS)) chk (.*);
